// ### logic/rmct_pkg.sv
// Package of constants and types for the ring master cycle timing block
// Notes on behaviour
// (R1) Automatic: interrupt host on each returned sync
// (R2) Automatic: returned sync starts next cycle itself
// (R3) Automatic: ring transfer overlaps host processing
// (R4) External: each base tick starts a cycle
// (R5) External: sync after tick raises interrupt
// (R6) External: host processes only after interrupt
// (R7) External cyclic: tick starts cycle, host cyclic
// (R8) Cyclic-automatic: ring like automatic, host cyclic; here the host is still interrupted on every sync, as in automatic
// (R9) Host maps interrupt source to interrupt task
// (R10) Gap fill set: idle gaps carry filler frames
// (R11) Transmit enable clear: no frames sent
// (R12) Selector decoded at init; unknown is error
package rmct_pkg;
  localparam logic [3:0] RMCT_MODE_AUTO     = 4'h3;
  localparam logic [3:0] RMCT_MODE_EXT      = 4'h4;
  localparam logic [3:0] RMCT_MODE_EXT_CYC  = 4'h5;
  localparam logic [3:0] RMCT_MODE_CYC_AUTO = 4'ha;
  localparam int         RMCT_DATA_W        = 16;
  localparam int         RMCT_FIFO_DEPTH    = 8;
  localparam int         RMCT_FILL_GAP_CYC  = 4;

  // Cycle states, Gray coded along idle, send, wait, err
  typedef enum logic [1:0] {
    RMCT_ST_IDLE = 2'b00,
    RMCT_ST_SEND = 2'b01,
    RMCT_ST_WAIT = 2'b11,
    RMCT_ST_ERR  = 2'b10
  } rmct_state_t;
endpackage : rmct_pkg

// ### logic/rmct_stream_if.sv
// Interface carrying one valid/ready word stream between modules
`timescale 1ns/1ps
`default_nettype none
interface rmct_stream_if #(
  parameter int W = 16
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rmct_stream_if
`default_nettype wire

// ### logic/rmct_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rmct_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic clock,
  input  wire logic reset_n,
  rmct_stream_if.snk in_s,
  rmct_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (W < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("rmct_fifo width or depth out of range");
    end
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest full and empty from the fill count
  assign in_s.ready  = (cnt_q != DEPTH[AW:0]);
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data  = mem_q[rd_q];
  assign push = in_s.valid & in_s.ready;
  assign pop  = out_s.valid & out_s.ready;

  // Storage write
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  // Pointers and count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : rmct_fifo
`default_nettype wire

// ### logic/rmct_top.sv
// Ring master cycle timing: cycle start, filler frames and host interrupt
`timescale 1ns/1ps
`default_nettype none
module rmct_top #(
  parameter int DATA_W = rmct_pkg::RMCT_DATA_W,
  parameter int DEPTH  = rmct_pkg::RMCT_FIFO_DEPTH,
  parameter int GAP_CYC = rmct_pkg::RMCT_FILL_GAP_CYC
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              init,
  input  wire logic [3:0]        operation_selector,
  input  wire logic              gap_fill_option,
  input  wire logic              bus_transmit_enable,
  input  wire logic              base_tick,
  input  wire logic              sync_rx,
  input  wire logic [DATA_W-1:0] host_data,
  input  wire logic              host_valid,
  output logic                   host_ready,
  output logic [DATA_W-1:0]      tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic                   tx_filler,
  output logic                   cycle_start,
  output logic                   host_irq,
  output logic                   config_error
);
  initial begin
    if (DATA_W < 1 || GAP_CYC < 1 || GAP_CYC > 255) begin
      $error("rmct_top parameters out of range");
    end
  end

  // Pin synchronisers: first stage feeds only the second stage
  // Two flops per pin keep a metastable first stage away from logic
  logic [1:0] tick_s_q;
  logic [1:0] sync_s_q;
  logic       tick_d1_q;
  logic       sync_d1_q;
  logic       tick_ev;
  logic       sync_ev;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_s_q  <= 2'b00;
      sync_s_q  <= 2'b00;
      tick_d1_q <= 1'b0;
      sync_d1_q <= 1'b0;
    end else begin
      tick_s_q  <= {tick_s_q[0], base_tick};
      sync_s_q  <= {sync_s_q[0], sync_rx};
      tick_d1_q <= tick_s_q[1];
      sync_d1_q <= sync_s_q[1];
    end
  end

  // Rising edges taken from the second stage only
  // Edge flops reset low to match the idle pins: no false edge
  assign tick_ev = tick_s_q[1] & ~tick_d1_q;
  assign sync_ev = sync_s_q[1] & ~sync_d1_q;

  // Configuration latched on init only; later changes are ignored
  // Selector is watched all the time init is high; the last value counts
  logic [3:0] mode_q;
  logic       fill_q;
  logic       cfg_err_q;
  logic       cfg_ok_q;
  logic       sel_known;

  assign sel_known = (operation_selector == rmct_pkg::RMCT_MODE_AUTO)
                  || (operation_selector == rmct_pkg::RMCT_MODE_EXT)
                  || (operation_selector == rmct_pkg::RMCT_MODE_EXT_CYC)
                  || (operation_selector == rmct_pkg::RMCT_MODE_CYC_AUTO);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q    <= rmct_pkg::RMCT_MODE_AUTO;
      fill_q    <= 1'b0;
      cfg_err_q <= 1'b0;
      cfg_ok_q  <= 1'b0;
    end else if (init) begin
      mode_q    <= operation_selector; // (R12)
      fill_q    <= gap_fill_option;
      cfg_err_q <= ~sel_known; // (R12)
      cfg_ok_q  <= sel_known;
    end
  end

  // Mode classes: sync-driven versus tick-driven cycle start
  logic auto_cls;
  logic ext_cls;
  assign auto_cls = (mode_q == rmct_pkg::RMCT_MODE_AUTO)
                 || (mode_q == rmct_pkg::RMCT_MODE_CYC_AUTO); // (R8)
  assign ext_cls  = (mode_q == rmct_pkg::RMCT_MODE_EXT)
                 || (mode_q == rmct_pkg::RMCT_MODE_EXT_CYC);

  // Transmit enable is a level from the host side, synchronised too
  // Raising init also stops the run at once, before the flops settle
  logic [1:0] en_s_q;
  logic       run;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      en_s_q <= 2'b00;
    end else begin
      en_s_q <= {en_s_q[0], bus_transmit_enable};
    end
  end
  assign run = en_s_q[1] & cfg_ok_q & ~init; // (R11)

  // Cycle start decision
  // Sync-driven modes ignore ticks; tick-driven modes ignore syncs here
  logic start;
  always_comb begin
    start = 1'b0;
    if (run) begin
      if (auto_cls) begin
        start = sync_ev; // (R2)
      end else if (ext_cls) begin
        start = tick_ev; // (R4) (R7)
      end
    end
  end

  // Automatic modes need a first cycle after enable to prime the ring
  // Cleared with run so every re-enable primes the ring afresh
  logic primed_q;
  logic kick;
  assign kick = run & auto_cls & ~primed_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      primed_q <= 1'b0;
    end else if (!run) begin
      primed_q <= 1'b0;
    end else if (kick) begin
      primed_q <= 1'b1;
    end
  end

  // Buffer streams declared ahead of the state logic that reads them
  rmct_stream_if #(.W(DATA_W)) fifo_i ();
  rmct_stream_if #(.W(DATA_W)) fifo_o ();

  // Cycle state: send from FIFO, then wait for the returned sync
  // A cycle restart while still sending simply continues the drain,
  // so a late sync never strands words in the buffer
  rmct_pkg::rmct_state_t st_q;
  logic                  ext_armed_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= rmct_pkg::RMCT_ST_IDLE;
    end else if (!run) begin
      st_q <= cfg_err_q ? rmct_pkg::RMCT_ST_ERR : rmct_pkg::RMCT_ST_IDLE;
    end else if (start || kick) begin
      st_q <= rmct_pkg::RMCT_ST_SEND;
    end else begin
      case (st_q)
        rmct_pkg::RMCT_ST_SEND: begin
          if (!fifo_o.valid) begin
            st_q <= rmct_pkg::RMCT_ST_WAIT;
          end
        end
        rmct_pkg::RMCT_ST_WAIT: begin
          if (sync_ev) begin
            st_q <= rmct_pkg::RMCT_ST_IDLE;
          end
        end
        default: begin
          st_q <= rmct_pkg::RMCT_ST_IDLE;
        end
      endcase
    end
  end

  // External modes: interrupt only for a sync after a tick-started cycle
  // A tick in the same cycle as a sync wins, so the new cycle is armed
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_armed_q <= 1'b0;
    end else if (!run) begin
      ext_armed_q <= 1'b0;
    end else if (start && ext_cls) begin
      ext_armed_q <= 1'b1;
    end else if (sync_ev) begin
      ext_armed_q <= 1'b0;
    end
  end

  // Host ready is a flop: it holds the fill the buffer will have after
  // this edge, so it matches the buffer's own full flag in the same cycle and
  // leaves no combinational path from the buffer to the host pin
  localparam int CW = $clog2(DEPTH) + 1;
  logic [CW-1:0] occ_q;
  logic [CW-1:0] occ_d;
  logic          host_push;
  logic          host_pop;

  // Buffer's own ready kept in the term as a guard against drift
  assign host_push = host_valid & host_ready & fifo_i.ready;
  assign host_pop  = fifo_o.valid & fifo_o.ready;

  // Fill count after this edge
  always_comb begin
    occ_d = occ_q;
    if (host_push && !host_pop) begin
      occ_d = occ_q + 1'b1;
    end else if (host_pop && !host_push) begin
      occ_d = occ_q - 1'b1;
    end
  end

  // Ready high in reset: an empty buffer always has room
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      occ_q      <= '0;
      host_ready <= 1'b1;
    end else begin
      occ_q      <= occ_d;
      host_ready <= (occ_d != CW'(DEPTH));
    end
  end

  // Host data buffered so the host can refill while the ring runs
  assign fifo_i.data  = host_data;
  assign fifo_i.valid = host_push;

  rmct_fifo #(
    .W     (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock   (clock),
    .reset_n (reset_n),
    .in_s    (fifo_i),
    .out_s   (fifo_o)
  );

  // Gap counter: idle time between cycles up to the threshold
  // Saturates at the threshold; any frame or cycle restarts the count
  logic [7:0] gap_q;
  logic       gap_due;
  assign gap_due = (gap_q == GAP_CYC[7:0]);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 8'h00;
    end else if (st_q != rmct_pkg::RMCT_ST_IDLE || !run || tx_valid) begin
      gap_q <= 8'h00;
    end else if (!gap_due) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // Output frame register; drains FIFO only while a cycle is sending
  // Disable drops a waiting frame: the ring is stopped anyway, and a
  // held frame would leak into the next enabled run
  logic sending;
  logic out_free;
  assign sending  = run && (st_q == rmct_pkg::RMCT_ST_SEND); // (R3)
  assign out_free = ~tx_valid | tx_ready;
  assign fifo_o.ready = sending & out_free;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_valid  <= 1'b0;
      tx_data   <= '0;
      tx_filler <= 1'b0;
    end else if (!run) begin
      tx_valid  <= 1'b0; // (R11)
      tx_filler <= 1'b0;
    end else if (out_free) begin
      if (sending && fifo_o.valid) begin
        tx_valid  <= 1'b1;
        tx_data   <= fifo_o.data;
        tx_filler <= 1'b0;
      end else if (fill_q && gap_due &&
                   st_q == rmct_pkg::RMCT_ST_IDLE) begin
        tx_valid  <= 1'b1; // (R10)
        tx_data   <= '0;
        tx_filler <= 1'b1;
      end else begin
        tx_valid  <= 1'b0;
        tx_filler <= 1'b0;
      end
    end
  end

  // Registered host signals; host_ready mirrors FIFO space
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cycle_start  <= 1'b0;
      host_irq     <= 1'b0;
      config_error <= 1'b0;
    end else begin
      cycle_start  <= start | kick;
      // Sync-driven modes interrupt on every sync; plain external on armed one, external cyclic never
      host_irq     <= run && sync_ev &&
                      ((auto_cls) || // (R1)
                       (mode_q == rmct_pkg::RMCT_MODE_EXT && ext_armed_q));
                      // (R5) (R6)
      config_error <= cfg_err_q; // (R12)
    end
  end

endmodule : rmct_top
`default_nettype wire

// ### verif/rmct_top_asserts.sv
// Timing checker for the ring master cycle block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module rmct_top_asserts #(
  parameter int DATA_W = 16
) (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              init,
  input wire logic [3:0]        operation_selector,
  input wire logic              gap_fill_option,
  input wire logic              bus_transmit_enable,
  input wire logic              base_tick,
  input wire logic              sync_rx,
  input wire logic [DATA_W-1:0] tx_data,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              tx_filler,
  input wire logic              cycle_start,
  input wire logic              host_irq,
  input wire logic              config_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic auto_m;
  logic ext_m;
  logic bad_m;
  // Mode groups; selector is held steady by the host after init
  assign auto_m = operation_selector == rmct_pkg::RMCT_MODE_AUTO
    || operation_selector == rmct_pkg::RMCT_MODE_CYC_AUTO;
  assign ext_m = operation_selector == rmct_pkg::RMCT_MODE_EXT
    || operation_selector == rmct_pkg::RMCT_MODE_EXT_CYC;
  assign bad_m = !(auto_m || ext_m);
  // Enable must have crossed the synchroniser before we expect work
  sequence s_run;
    !init && !config_error && bus_transmit_enable
      && $past(bus_transmit_enable, 4);
  endsequence
  sequence s_sync_auto;
    s_run ##0 (auto_m && $rose(sync_rx));
  endsequence
  property p_irq_auto;
    s_sync_auto |-> ##[2:5] host_irq;
  endproperty
  a_irq_auto: assert property (p_irq_auto)
    else $error("no interrupt after returned sync");
  property p_start_auto;
    s_sync_auto |-> ##[2:5] cycle_start;
  endproperty
  a_start_auto: assert property (p_start_auto)
    else $error("returned sync did not restart cycle");
  property p_start_ext;
    s_run ##0 (ext_m && $rose(base_tick)) |-> ##[2:5] cycle_start;
  endproperty
  a_start_ext: assert property (p_start_ext)
    else $error("base tick did not start cycle");
  property p_no_irq_cyc;
    (!init && operation_selector == rmct_pkg::RMCT_MODE_EXT_CYC) [*8]
      |-> !host_irq;
  endproperty
  a_no_irq_cyc: assert property (p_no_irq_cyc)
    else $error("interrupt in external cyclic mode");
  property p_quiet;
    !bus_transmit_enable [*5] |-> !tx_valid;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("frame sent while disabled");
  property p_hold;
    tx_valid && !tx_ready && bus_transmit_enable
      |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame changed before taken");
  property p_fill_zero;
    tx_valid && tx_filler |-> tx_data == '0;
  endproperty
  a_fill_zero: assert property (p_fill_zero)
    else $error("filler frame carries data");
  property p_no_fill;
    !gap_fill_option && !init |-> !(tx_valid && tx_filler);
  endproperty
  a_no_fill: assert property (p_no_fill)
    else $error("filler sent with gap fill off");
  property p_cfg;
    $fell(init) |-> ##2 (config_error == bad_m);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("configuration error flag wrong");
  property p_pulse;
    cycle_start |=> !cycle_start;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("cycle start longer than one cycle");
endmodule : rmct_top_asserts
bind rmct_top rmct_top_asserts #(.DATA_W(DATA_W)) u_chk (
  .clock(clock), .reset_n(reset_n), .init(init),
  .operation_selector(operation_selector),
  .gap_fill_option(gap_fill_option),
  .bus_transmit_enable(bus_transmit_enable), .base_tick(base_tick),
  .sync_rx(sync_rx), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .tx_filler(tx_filler),
  .cycle_start(cycle_start), .host_irq(host_irq),
  .config_error(config_error));
`default_nettype wire

// ### verif/rmct_ring_model.sv
// Behavioural ring of slave nodes: takes frames, returns the sync
`timescale 1ns/1ps
`default_nettype none
module rmct_ring_model #(
  parameter int LAT = 40
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic stall,
  input  wire logic cycle_start,
  output logic      tx_ready,
  output logic      sync_rx
);
  int         cnt_q;
  logic [1:0] ph_q;
  // Slow ring takes one frame in four; sync returns LAT after start
  always_ff @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 0;
      ph_q <= 2'h0;
      tx_ready <= 1'b0;
      sync_rx <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      tx_ready <= !stall || ph_q == 2'h0;
      cnt_q <= cycle_start ? LAT : (cnt_q > 0 ? cnt_q - 1 : 0);
      sync_rx <= cnt_q > 0 && cnt_q <= 4; // Sync held four clocks
    end
  end
endmodule : rmct_ring_model
`default_nettype wire

// ### verif/rmct_top_tb.sv
// Self-checking bench: modes, filler, enable, buffer and interrupts
`timescale 1ns/1ps
`default_nettype none
module rmct_top_tb;
  logic        clock = 0, reset_n = 0, init = 0, gap = 0, en = 0;
  logic        tick = 0, hvalid = 0, stall = 0, hready, tx_valid;
  logic        tx_ready, tx_filler, cs, irq, cerr, sync_rx;
  logic [3:0]  sel = 4'h0;
  logic [15:0] hdata = 16'h0, tx_data, exp_q[$];
  int          n_mismatch = 0, samples_checked = 0, seed = 32'h8d21;
  int          n_irq = 0, n_cs = 0, n_fill = 0, n_sync = 0;
  logic [3:0]  modes [4] = '{4'h3, 4'h4, 4'h5, 4'ha};
  always #10 clock = ~clock;
  rmct_top uut (.clock(clock), .reset_n(reset_n), .init(init),
    .operation_selector(sel), .gap_fill_option(gap),
    .bus_transmit_enable(en), .base_tick(tick), .sync_rx(sync_rx),
    .host_data(hdata), .host_valid(hvalid), .host_ready(hready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_filler(tx_filler), .cycle_start(cs), .host_irq(irq),
    .config_error(cerr));
  rmct_ring_model ring (.clock(clock), .reset_n(reset_n),
    .stall(stall), .cycle_start(cs), .tx_ready(tx_ready),
    .sync_rx(sync_rx));
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Watcher: data frames must match the oldest pushed word
  always @(posedge clock) begin
    if (tx_valid && tx_ready && !tx_filler) begin
      chk(exp_q.size() != 0 ? exp_q.pop_front() : 16'hdead, tx_data);
    end
    if (tx_valid && tx_ready && tx_filler) n_fill++;
    if (irq === 1'b1) n_irq++;
    if (cs === 1'b1) n_cs++;
  end
  always @(posedge sync_rx) n_sync++;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic setup(input logic [3:0] m, input logic g);
    init = 1'b1;
    sel = m;
    gap = g;
    cyc(4);
    init = 1'b0;
    cyc(6);
  endtask : setup
  // Host push; a word refused by a full buffer is not expected out
  task automatic push();
    @(negedge clock);
    hdata = 16'($random(seed));
    hvalid = 1'b1;
    #1 if (hready === 1'b1) exp_q.push_back(hdata);
    @(negedge clock);
    hvalid = 1'b0;
  endtask : push
  task automatic run_mode(input logic [3:0] m);
    logic ext;
    ext = m == 4'h4 || m == 4'h5;
    setup(m, ext);
    chk(16'h0, 16'(cerr));
    stall = m[0];
    for (int k = 0; k < 9; k++) push();
    chk(16'h8, 16'(exp_q.size()));
    n_irq = 0;
    n_cs = 0;
    n_fill = 0;
    n_sync = 0;
    en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      tick = ext;
      cyc(4);
      tick = 1'b0;
      cyc(296);
      if (ext && k < 3) push();
    end
    chk(16'h0, 16'(exp_q.size()));
    chk(16'(ext), 16'(n_fill != 0));
    if (m == 4'h5) chk(16'h0, 16'(n_irq));
    if (ext) chk(16'h4, 16'(n_cs));
    if (m == 4'h4) chk(16'(n_sync), 16'(n_irq));
    if (m == 4'h4) chk(16'h4, 16'(n_sync));
    if (!ext) chk(16'h1, 16'(n_irq > 5 && n_cs > 5));
    en = 1'b0;
    cyc(100);
  endtask : run_mode
  initial begin
    repeat (5) @(negedge clock);
    chk(16'h1, 16'(hready));
    chk(16'h0, 16'(tx_valid));
    reset_n = 1'b1;
    setup(4'h7, 1'b0);
    chk(16'h1, 16'(cerr));
    en = 1'b1;
    cyc(60);
    chk(16'h0, 16'(n_cs));
    en = 1'b0;
    foreach (modes[i]) run_mode(modes[i]);
    end_of_test();
  end
  // Run takes about 110 us; a hang is cut short well beyond that
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
endmodule : rmct_top_tb
`default_nettype wire
